// *** tb/tb.sv ***
/*
 * Self-checking bench of the two-wire control and status block.
 * Assumes the checker and bus model files are compiled first.
 */
`timescale 1ns/1ps
module tb;
    logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic scl_out, scl_oe, irq, scl_low, sda_low;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, a;
    logic [31:0] seed = 32'hEF20A78B;
    logic [31:0] exp_q[$], msk_q[$];
    int error_cnt = 0;
    int check_count = 0;
    int pulses = 0;
    wire scl_line = ~(scl_low | (scl_oe & ~scl_out));
    wire sda_line = ~sda_low;
    twowire_bus_control_status #(.TOGGLE_HALF(4)) i_twowire_bus_control_status (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_line), .irq(irq));
    twowire_bus_model i_twowire_bus_model (.scl_low(scl_low), .sda_low(sda_low));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, ad, 32'h0);
    endtask : rd
    always @(posedge sys_clk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());
        end
    end
    always @(posedge scl_oe) pulses++;
    task automatic final_report();
        if (exp_q.size() != 0) begin
            error_cnt++;
        end
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        apb(1'b1, 8'h08, 32'hFE);
        rd(8'h08, 32'h0, 32'hFFFFFFEF);
        rd(8'h3C, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            apb(1'b1, 8'h0C, seed);
            rd(8'h0C, seed & 32'hFF, 32'hFFFFFFFF);
            apb(1'b1, 8'h10, seed >> 8);
            rd(8'h10, (seed >> 8) & 32'hFF, 32'hFFFFFFFF);
        end
        $display("register test done");
        apb(1'b1, 8'h20, 32'h1);
        a = (seed | 32'h2) & 32'h7F;
        apb(1'b1, 8'h10, a | 32'h80);
        i_twowire_bus_model.start();
        cyc(6);
        rd(8'h08, 32'h3, 32'hF);
        i_twowire_bus_model.send({a[6:0], 1'b0});
        cyc(6);
        rd(8'h08, 32'h6, 32'hF);
        i_twowire_bus_model.release_lines();
        cyc(6);
        apb(1'b1, 8'h08, 32'h2);
        rd(8'h08, 32'h4, 32'hF);
        i_twowire_bus_model.start();
        i_twowire_bus_model.send({a[6:0] ^ 7'h01, 1'b0});
        cyc(6);
        rd(8'h08, 32'h2, 32'hF);
        i_twowire_bus_model.stop();
        cyc(6);
        rd(8'h08, 32'h0, 32'hF);
        apb(1'b1, 8'h10, a);
        i_twowire_bus_model.start();
        i_twowire_bus_model.send({a[6:0], 1'b0});
        cyc(6);
        rd(8'h08, 32'h2, 32'hF);
        i_twowire_bus_model.stop();
        cyc(6);
        apb(1'b1, 8'h10, a | 32'h80);
        $display("address test done");
        for (int g = 0; g < 2; g++) begin
            apb(1'b1, 8'h0C, g << 5);
            i_twowire_bus_model.start();
            i_twowire_bus_model.send(8'h00);
            cyc(6);
            rd(8'h08, g ? 32'hA : 32'h2, 32'hF);
            i_twowire_bus_model.stop();
            cyc(6);
        end
        i_twowire_bus_model.start();
        i_twowire_bus_model.send({a[6:0], 1'b0});
        apb(1'b1, 8'h20, 32'h0);
        rd(8'h08, 32'h0, 32'hFFFFFFEF);
        i_twowire_bus_model.stop();
        apb(1'b1, 8'h20, 32'h1);
        $display("general call and disable test done");
        rd(8'h24, 32'h7, 32'hF);
        i_twowire_bus_model.start();
        cyc(6);
        rd(8'h08, 32'h0, 32'h10);
        apb(1'b1, 8'h08, 32'h20);
        rd(8'h08, 32'h20, 32'h20);
        cyc(12);
        rd(8'h08, 32'h0, 32'h20);
        chk("pulses", 32'h1, pulses);
        chk("irq", 32'h0, irq);
        apb(1'b1, 8'h28, 32'h8);
        cyc(1);
        chk("irq", 32'h1, irq);
        rd(8'h24, 32'h8, 32'h8);
        cyc(1);
        chk("irq", 32'h0, irq);
        i_twowire_bus_model.release_lines();
        cyc(6);
        apb(1'b1, 8'h08, 32'h30);
        cyc(2);
        rd(8'h08, 32'h10, 32'h30);
        chk("pulses", 32'h1, pulses);
        $display("toggle test done");
        cyc(2);
        final_report();
    end
endmodule : tb

// *** tb/twowire_assertions.sv ***
/*
 * Port checks of the two-wire control and status block.
 * Assumes TOGGLE_HALF is at most 255 and the lines are resolved outside.
 */
`timescale 1ns/1ps
module twowire_assertions #(
    parameter int ADDR_W = 8,
    parameter int TOGGLE_HALF = 4
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Bus lines and interrupt
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic irq
);
    logic [4:0] sda_h_r;
    logic en_r;
    logic [7:0] cnt_r;
    wire acc = psel && penable && pready;
    wire rd_set = psel && !penable && !pwrite && paddr == 8'h08;
    wire wr_tgl = acc && pwrite && paddr == 8'h08 && pwdata[5];
    // The line must sit still across the synchroniser before a sample counts.
    wire sda_hi = &{sda_h_r, sda_in};
    wire sda_lo = ~|{sda_h_r, sda_in};
    wire [4:0] sda_h_nxt = {sda_h_r[3:0], sda_in};
    wire en_nxt = (acc && pwrite && paddr == 8'h20) ? pwdata[0] : en_r;
    wire [7:0] cnt_nxt = scl_oe ? cnt_r + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sda_h_r <= 5'h00;
            en_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            sda_h_r <= sda_h_nxt;
            en_r <= en_nxt;
            cnt_r <= cnt_nxt;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    reserved_zero_a: assert property (rd_set |=> prdata[31:6] == 26'h0)
        else $error("reserved status bits not zero");
    sample_live_a: assert property (rd_set && (sda_hi || sda_lo) |=>
        prdata[4] == $past(sda_in))
        else $error("data line sample wrong");
    toggle_start_a: assert property (wr_tgl && en_r && sda_lo && !scl_oe |=> scl_oe)
        else $error("toggle not started");
    toggle_ignore_a: assert property (wr_tgl && sda_hi && !scl_oe |=> !scl_oe [*4])
        else $error("toggle with data high");
    toggle_len_a: assert property ($fell(scl_oe) |-> cnt_r == TOGGLE_HALF)
        else $error("toggle low phase length wrong");
    toggle_gap_a: assert property ($fell(scl_oe) |-> !scl_oe [*4])
        else $error("more than one toggle cycle");
    // The status clears one edge after the disabling write lands.
    disabled_clear_a: assert property (rd_set && !en_r && !$past(en_r) |=>
        (prdata[5:0] & 6'h2F) == 6'h00)
        else $error("status set while disabled");
    occupied_low_a: assert property (rd_set && en_r && $past(en_r) && sda_lo |=> prdata[1])
        else $error("occupied clear with line low");
    bad_addr_a: assert property (psel && penable && paddr == 8'h3C |-> pslverr)
        else $error("unmapped access not refused");
    cover property (wr_tgl && sda_lo);
    cover property (rd_set && sda_hi);
    cover property ($rose(irq));
endmodule : twowire_assertions

bind twowire_bus_control_status twowire_assertions #(.ADDR_W(ADDR_W),
    .TOGGLE_HALF(TOGGLE_HALF)) i_twowire_assertions (.sys_clk(sys_clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .irq(irq));

// *** tb/twowire_bus_model.sv ***
/*
 * Far side of the two-wire bus: start, stop and bytes at a 160 ns bit time.
 * Assumes the bench resolves both lines with pull-ups.
 */
`timescale 1ns/1ps
module twowire_bus_model (
    // Pulls, high while this model holds a line low
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    // Offset of 3 ns keeps the changes of start off the system clock edges.
    task automatic start();
        #3 sda_low = 1'b1;
        #80 scl_low = 1'b1;
    endtask : start
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #40 sda_low = ~b[i];
            #40 scl_low = 1'b0;
            #80 scl_low = 1'b1;
        end
    endtask : send
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl_low = 1'b0;
        #80 sda_low = 1'b0;
    endtask : stop
    // Data changes while the clock is low, so no stop is seen.
    task automatic release_lines();
        #40 sda_low = 1'b0;
        #40 scl_low = 1'b0;
    endtask : release_lines
endmodule : twowire_bus_model

// *** verilog/twowire_bus_control_status.sv ***
/*
 * Control and status logic of a two-wire bus controller: bus occupancy,
 * transfer phase up to the address byte, address and general call matches,
 * data line sampling and clock toggling for bus recovery, with an APB slave
 * and a level interrupt.
 * Assumes an APB master on sys_clk and open-drain bus lines resolved outside.
 */
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "twowire_params.svh"
module twowire_bus_control_status
    import twowire_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int TOGGLE_HALF = `TW_TOGGLE_HALF_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Two-wire bus lines
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    // Interrupt
    output logic irq
);
    localparam int CNT_W = $clog2(TOGGLE_HALF + 1);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(TOGGLE_HALF - 1);

    logic scl_sync;
    logic sda_sync;
    logic scl_rise;
    logic start_det;
    logic stop_det;

    twowire_line_monitor i_twowire_line_monitor (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_sync(scl_sync),
        .sda_sync(sda_sync),
        .scl_rise(scl_rise),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    // Bus decode.
    logic [5:0] idx;
    logic addr_ok;
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic sel_cst;
    logic sel_ctl1;
    logic sel_own;
    logic sel_en;
    logic sel_ist;
    logic sel_imask;

    assign idx = paddr[7:2];
    assign sel_cst = idx == `TW_IDX_CST;
    assign sel_ctl1 = idx == `TW_IDX_CTL1;
    assign sel_own = idx == `TW_IDX_OWNADDR;
    assign sel_en = idx == `TW_IDX_ENABLE;
    assign sel_ist = idx == `TW_IDX_IRQ_ST;
    assign sel_imask = idx == `TW_IDX_IRQ_MASK;
    assign addr_ok = (paddr[1:0] == 2'h0) &&
        (sel_cst || sel_ctl1 || sel_own || sel_en || sel_ist || sel_imask);
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr = access & pwrite & addr_ok;
    assign rd = access & ~pwrite & addr_ok;
    assign pready = 1'b1;
    assign pslverr = access & ~addr_ok;

    // Software registers.
    logic [7:0] ctl1_r;
    logic [7:0] ctl1_nxt;
    logic [7:0] own_r;
    logic [7:0] own_nxt;
    logic enable_r;
    logic enable_nxt;
    logic [`TW_IRQ_W-1:0] imask_r;
    logic [`TW_IRQ_W-1:0] imask_nxt;

    // Bus state.
    toggle_state_e tgl_r;
    toggle_state_e tgl_nxt;
    logic [CNT_W-1:0] tcnt_r;
    logic [CNT_W-1:0] tcnt_nxt;
    logic toggle_bit_r;
    logic toggle_bit_nxt;
    addr_phase_e ph_r;
    addr_phase_e ph_nxt;
    logic [3:0] bitcnt_r;
    logic [3:0] bitcnt_nxt;
    logic [`TW_ADDR_BITS-1:0] shift_r;
    logic [`TW_ADDR_BITS-1:0] shift_nxt;
    logic busy_r;
    logic busy_nxt;
    logic occupied_r;
    logic occupied_nxt;
    logic addr_hit_r;
    logic addr_hit_nxt;
    logic gc_hit_r;
    logic gc_hit_nxt;
    logic [`TW_IRQ_W-1:0] ist_r;
    logic [`TW_IRQ_W-1:0] ist_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    logic [7:0] cst_view;
    logic [`TW_ADDR_BITS-1:0] byte_done;
    logic addr_end;
    logic addr_hit_now;
    logic gc_hit_now;
    logic toggle_done;
    logic cst_wr;

    assign cst_wr = wr & sel_cst;
    assign byte_done = {shift_r[`TW_ADDR_BITS-2:0], sda_sync};
    assign addr_end = (ph_r == PH_ADDR) && scl_rise &&
        (bitcnt_r == 4'(`TW_ADDR_BITS - 1)) && !start_det;
    assign addr_hit_now = addr_end && own_r[`TW_OWN_SLAVE_ADDRESS_ENABLE] &&
        (byte_done[7:1] == own_r[6:0]); // RL6
    assign gc_hit_now = addr_end && ctl1_r[`TW_CTL1_GENERAL_CALL_ENABLE] &&
        (byte_done == 8'h00); // RL5 RL13
    assign toggle_done = (tgl_r == TGL_HIGH) && (tcnt_r == HALF_LAST);

    always_comb begin
        cst_view = 8'h00; // RL14
        cst_view[`TW_CST_CLOCK_TOGGLE] = toggle_bit_r;
        cst_view[`TW_CST_DATA_LINE_SAMPLE] = sda_sync; // RL4
        cst_view[`TW_CST_GENERAL_CALL_HIT] = gc_hit_r;
        cst_view[`TW_CST_ADDR_HIT] = addr_hit_r;
        cst_view[`TW_CST_BUS_OCCUPIED] = occupied_r;
        cst_view[`TW_CST_TRANSFER_BUSY] = busy_r;
    end

    // Software register writes.
    always_comb begin
        ctl1_nxt = ctl1_r;
        own_nxt = own_r;
        enable_nxt = enable_r;
        imask_nxt = imask_r;
        if (wr && sel_ctl1) begin
            ctl1_nxt = pwdata[7:0];
        end
        if (wr && sel_own) begin
            own_nxt = pwdata[7:0];
        end
        if (wr && sel_en) begin
            enable_nxt = pwdata[0];
        end
        if (wr && sel_imask) begin
            imask_nxt = pwdata[`TW_IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctl1_r <= `TW_RST_BYTE;
            own_r <= `TW_RST_BYTE;
            enable_r <= 1'b0;
            imask_r <= `TW_RST_IRQ;
        end else begin
            ctl1_r <= ctl1_nxt;
            own_r <= own_nxt;
            enable_r <= enable_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Clock toggle for recovering a bus held low by a lost slave.
    always_comb begin
        tgl_nxt = tgl_r;
        tcnt_nxt = tcnt_r;
        toggle_bit_nxt = toggle_bit_r;
        case (tgl_r)
            TGL_IDLE: begin
                // Writing one with data high starts nothing.
                if (cst_wr && pwdata[`TW_CST_CLOCK_TOGGLE] && !sda_sync) begin // RL2 RL3
                    tgl_nxt = TGL_LOW;
                    tcnt_nxt = '0;
                    toggle_bit_nxt = 1'b1;
                end
            end
            TGL_LOW: begin
                tcnt_nxt = tcnt_r + 1'b1;
                if (tcnt_r == HALF_LAST) begin
                    tgl_nxt = TGL_HIGH;
                    tcnt_nxt = '0;
                end
            end
            TGL_HIGH: begin
                tcnt_nxt = tcnt_r + 1'b1;
                if (toggle_done) begin
                    tgl_nxt = TGL_IDLE;
                    tcnt_nxt = '0;
                    toggle_bit_nxt = 1'b0; // RL2
                end
            end
            default: begin
                tgl_nxt = TGL_IDLE;
                tcnt_nxt = '0;
                toggle_bit_nxt = 1'b0;
            end
        endcase
        if (!enable_r) begin // RL1
            tgl_nxt = TGL_IDLE;
            tcnt_nxt = '0;
            toggle_bit_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tgl_r <= TGL_IDLE;
            tcnt_r <= '0;
            toggle_bit_r <= 1'b0;
        end else begin
            tgl_r <= tgl_nxt;
            tcnt_r <= tcnt_nxt;
            toggle_bit_r <= toggle_bit_nxt;
        end
    end

    // The clock is only ever pulled low; high is left to the pull-up.
    assign scl_out = 1'b0;
    assign scl_oe = (tgl_r == TGL_LOW); // RL2

    // Address phase, matches and bus occupancy.
    always_comb begin
        ph_nxt = ph_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt = shift_r;
        busy_nxt = busy_r;
        addr_hit_nxt = addr_hit_r;
        gc_hit_nxt = gc_hit_r;
        occupied_nxt = occupied_r;
        if (start_det) begin
            ph_nxt = PH_ADDR;
            bitcnt_nxt = 4'h0;
            busy_nxt = 1'b1; // RL10
            addr_hit_nxt = 1'b0; // RL7
            gc_hit_nxt = 1'b0; // RL7
        end else if (stop_det) begin
            ph_nxt = PH_IDLE;
            busy_nxt = 1'b0;
            addr_hit_nxt = 1'b0; // RL7
            gc_hit_nxt = 1'b0; // RL7
        end else if (ph_r == PH_ADDR && scl_rise) begin
            shift_nxt = byte_done;
            bitcnt_nxt = bitcnt_r + 4'h1;
            if (addr_end) begin
                ph_nxt = PH_DONE;
                busy_nxt = 1'b0; // RL11
                addr_hit_nxt = addr_hit_now;
                gc_hit_nxt = gc_hit_now;
            end
        end
        // Write-one and stop clears come before the set so that a simultaneous set wins.
        if (cst_wr && pwdata[`TW_CST_BUS_OCCUPIED]) begin
            occupied_nxt = 1'b0; // RL9
        end
        if (stop_det) begin
            occupied_nxt = 1'b0; // RL9
        end
        if (start_det || !sda_sync || !scl_sync) begin
            occupied_nxt = 1'b1; // RL8
        end
        if (!enable_r) begin // RL1
            ph_nxt = PH_IDLE;
            bitcnt_nxt = 4'h0;
            busy_nxt = 1'b0; // RL11
            addr_hit_nxt = 1'b0;
            gc_hit_nxt = 1'b0;
            occupied_nxt = 1'b0; // RL9
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ph_r <= PH_IDLE;
            bitcnt_r <= 4'h0;
            shift_r <= `TW_RST_BYTE;
            busy_r <= 1'b0;
            addr_hit_r <= 1'b0;
            gc_hit_r <= 1'b0;
            occupied_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            bitcnt_r <= bitcnt_nxt;
            shift_r <= shift_nxt;
            busy_r <= busy_nxt;
            addr_hit_r <= addr_hit_nxt;
            gc_hit_r <= gc_hit_nxt;
            occupied_r <= occupied_nxt;
        end
    end

    // Sticky interrupt status, cleared by a read; a new event wins.
    logic [`TW_IRQ_W-1:0] ev;

    always_comb begin
        ev = '0;
        ev[`TW_IRQ_START] = start_det & enable_r;
        ev[`TW_IRQ_STOP] = stop_det & enable_r;
        ev[`TW_IRQ_NEW_MATCH] = (addr_hit_now | gc_hit_now) & enable_r;
        ev[`TW_IRQ_TOGGLE_DONE] = toggle_done & enable_r;
        ist_nxt = ist_r;
        // Only the bits that the read reported are cleared, so an event that
        // lands between the setup and access edges is not lost unseen.
        if (rd && sel_ist) begin
            ist_nxt = ist_r & ~prdata_r[`TW_IRQ_W-1:0];
        end
        ist_nxt = ist_nxt | ev;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ist_r <= `TW_RST_IRQ;
        end else begin
            ist_r <= ist_nxt;
        end
    end

    assign irq = |(ist_r & imask_r);

    // Read data is captured in the setup cycle, so the slave needs no wait.
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup) begin
            prdata_nxt = 32'h0000_0000;
            case (idx)
                `TW_IDX_CST: prdata_nxt[7:0] = cst_view;
                `TW_IDX_CTL1: prdata_nxt[7:0] = ctl1_r;
                `TW_IDX_OWNADDR: prdata_nxt[7:0] = own_r;
                `TW_IDX_ENABLE: prdata_nxt[0] = enable_r;
                `TW_IDX_IRQ_ST: prdata_nxt[`TW_IRQ_W-1:0] = ist_r;
                `TW_IDX_IRQ_MASK: prdata_nxt[`TW_IRQ_W-1:0] = imask_r;
                default: prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;

endmodule : twowire_bus_control_status

// *** verilog/twowire_line_monitor.sv ***
/*
 * Synchronises the two bus lines into the system clock domain and finds
 * clock rising edges and start and stop conditions.
 * Assumes the lines are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
module twowire_line_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Raw lines
    input wire logic scl_in,
    input wire logic sda_in,
    // Synchronised levels and events
    output logic scl_sync,
    output logic sda_sync,
    output logic scl_rise,
    output logic start_det,
    output logic stop_det
);
    logic [1:0] meta_r;
    logic [1:0] meta_nxt;
    logic [1:0] sync_r;
    logic [1:0] sync_nxt;
    logic [1:0] prev_r;
    logic [1:0] prev_nxt;

    always_comb begin
        meta_nxt = {scl_in, sda_in};
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // Idle bus level is high, so all stages reset high.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
            prev_r <= 2'h3;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign scl_sync = sync_r[1];
    assign sda_sync = sync_r[0];
    assign scl_rise = sync_r[1] & ~prev_r[1];
    // A data change while the clock stays high marks start or stop.
    assign start_det = sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
    assign stop_det = sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];

endmodule : twowire_line_monitor

// *** verilog/twowire_params.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the two-wire
 * bus control and status block. Assumes the includer runs on a 100 MHz clock.
 */
// Overview of operation
// RL1: Disable or reset clears all non-reserved status bits; the code leaves the data sample bit following the line.
// RL2: Toggle write with data low: one clock cycle.
// RL3: Toggle write with data high is ignored.
// RL4: Data sample bit reads live line, read-only.
// RL5: General call hit on first byte 00h.
// RL6: Address match on upper seven bits.
// RL7: Start or stop clears both match flags.
// RL8: Start or any low line sets occupied.
// RL9: Write one, disable or stop clears occupied.
// RL10: Transfer busy from start to address end.
// RL11: Transfer busy clears after address or disable.
// RL12: Software writes zero to transfer busy bit.
// RL13: General call ignored unless enabled.
// RL14: Reserved upper bits read zero, writes ignored.
`ifndef TWOWIRE_PARAMS_SVH
`define TWOWIRE_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define TW_IDX_CST 6'h02
`define TW_IDX_CTL1 6'h03
`define TW_IDX_OWNADDR 6'h04
`define TW_IDX_ENABLE 6'h08
`define TW_IDX_IRQ_ST 6'h09
`define TW_IDX_IRQ_MASK 6'h0A

// Fields of bus_control_status.
`define TW_CST_TRANSFER_BUSY 0
`define TW_CST_BUS_OCCUPIED 1
`define TW_CST_ADDR_HIT 2
`define TW_CST_GENERAL_CALL_HIT 3
`define TW_CST_DATA_LINE_SAMPLE 4
`define TW_CST_CLOCK_TOGGLE 5

// Fields of bus_control_one and own_slave_address.
`define TW_CTL1_GENERAL_CALL_ENABLE 5
`define TW_OWN_SLAVE_ADDRESS_ENABLE 7

// Interrupt status and mask fields.
`define TW_IRQ_START 0
`define TW_IRQ_STOP 1
`define TW_IRQ_NEW_MATCH 2
`define TW_IRQ_TOGGLE_DONE 3
`define TW_IRQ_W 4

// Reset values.
`define TW_RST_BYTE 8'h00
`define TW_RST_IRQ 4'h0

// Clock toggle timing: each half of the generated cycle.
`define TW_SYS_CLK_MHZ 100
`define TW_TOGGLE_HALF_NS 5000
`define TW_TOGGLE_HALF_CYC ((`TW_TOGGLE_HALF_NS * `TW_SYS_CLK_MHZ) / 1000)

`define TW_ADDR_BITS 8

`endif

// *** verilog/twowire_pkg.sv ***
/*
 * Types shared by the two-wire bus control and status block.
 * Assumes nothing of its surroundings.
 */
package twowire_pkg;

    typedef enum logic [1:0] {
        TGL_IDLE,
        TGL_LOW,
        TGL_HIGH
    } toggle_state_e;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DONE
    } addr_phase_e;

endpackage : twowire_pkg
